// ===== rtl/conv_control_consts.svh
// register offsets, field positions, reset values and timing counts of the converter control block
// assumes a 16-bit internal bus with word index addressing
`ifndef CONV_CONTROL_CONSTS_SVH
`define CONV_CONTROL_CONSTS_SVH
`define CONV_CONTROL_IDX_RESULT_A 4'h0
`define CONV_CONTROL_IDX_CTRL_STATUS 4'h8
`define CONV_CONTROL_IDX_CONV_CONTROL 4'h9
`define CONV_CONTROL_BIT_END_FLAG 7
`define CONV_CONTROL_BIT_IRQ_EN 6
`define CONV_CONTROL_BIT_START 5
`define CONV_CONTROL_BIT_RSVD 4
`define CONV_CONTROL_CSR_RESET 8'h00
`define CONV_CONTROL_CR_RESET 8'h00
`define CONV_CONTROL_BIT_SCAN_EN 0
`define CONV_CONTROL_BIT_SCAN_SIZE 1
`define CONV_CONTROL_BIT_TRIG_EN 2
`define CONV_CONTROL_RES_LSB 6
`define CONV_CONTROL_CONV_TIME_NS 3400
`define CONV_CONTROL_CLK_PERIOD_NS 4
`define CONV_CONTROL_CONV_CYCLES (`CONV_CONTROL_CONV_TIME_NS / `CONV_CONTROL_CLK_PERIOD_NS)
`endif

// ===== rtl/conv_control_pkg.sv
// types shared by the converter control block
// assumes the constants header sits beside it
package conv_control_pkg;
    typedef logic [9:0] conv_control_sample_t;
    typedef logic [2:0] conv_control_chan_t;
    typedef enum logic [1:0] {
        CONV_CONTROL_IDLE = 2'b00,
        CONV_CONTROL_CONV = 2'b01,
        CONV_CONTROL_NEXT = 2'b10
    } conv_control_state_e;
endpackage

// ===== rtl/conv_control_sync.sv
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ps
module conv_control_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule

// ===== rtl/conv_control_timer.sv
// conversion time counter: a start pulse gives a done pulse after a fixed number of cycles
// assumes start only arrives while idle or is ignored while busy
`timescale 1ns/1ps
`include "conv_control_consts.svh"
module conv_control_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    output logic done
);
    logic [11:0] cnt_ff;
    logic [11:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        if (abort) begin
            nxt_cnt = 12'h000;
        end else if (cnt_ff != 12'h000) begin
            nxt_cnt = cnt_ff - 12'h001;
            nxt_done = (cnt_ff == 12'h001);
        end else if (start) begin
            nxt_cnt = 12'(`CONV_CONTROL_CONV_CYCLES);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= 12'h000;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end
    assign done = done_ff;
endmodule

// ===== rtl/conv_control_top.sv
// converter control unit: eight result registers, control/status and control registers
// assumes a 16-bit internal bus, an analog core supplying a 10-bit sample per channel
`timescale 1ns/1ps
`include "conv_control_consts.svh"
module conv_control_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic bus_word,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_dma,
    output logic [15:0] bus_rdata,
    input wire logic ext_trigger_u0,
    input wire logic [9:0] sample_data,
    output logic [2:0] sample_chan,
    output logic sample_hold,
    output logic conv_end_irq
);
    import conv_control_pkg::*;

    logic trig_sync;
    logic trig_prev_ff;
    logic trig_edge;
    logic conv_done;
    logic conv_go;
    logic conv_abort;

    // pin passes two flip-flops before any logic reads it
    conv_control_sync u_trig_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(ext_trigger_u0),
        .sync_out(trig_sync)
    );

    conv_control_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(conv_go),
        .abort(conv_abort),
        .done(conv_done)
    );

    // word decode shared by the read data and dma acknowledge paths
    function automatic logic is_result(input logic [3:0] a);
        return a[3] == 1'b0;
    endfunction

    logic end_flag_ff, nxt_end_flag;
    logic irq_en_ff, nxt_irq_en;
    logic start_ff, nxt_start;
    logic [3:0] chan_sel_ff, nxt_chan_sel;
    logic [7:0] conv_control_ff, nxt_conv_control;
    logic flag_seen_ff, nxt_flag_seen;
    conv_control_state_e state_ff, nxt_state;
    conv_control_chan_t cur_ff, nxt_cur;
    conv_control_sample_t result_ff [0:7];
    logic [7:0] result_we;
    logic pass_end;
    logic [15:0] rdata_ff, nxt_rdata;
    logic irq_ff;
    logic [7:0] csr_view;
    logic scan_en;
    conv_control_chan_t last_chan;
    logic csr_wr;
    logic start_wr;

    assign scan_en = conv_control_ff[`CONV_CONTROL_BIT_SCAN_EN];
    assign csr_wr = bus_wr && (bus_addr == `CONV_CONTROL_IDX_CTRL_STATUS);
    assign trig_edge = trig_sync && !trig_prev_ff
                       && conv_control_ff[`CONV_CONTROL_BIT_TRIG_EN];
    // scan size select limits a pass to four channels, else eight; the
    // channel code then names the last channel of the pass
    assign last_chan = (scan_en && conv_control_ff[`CONV_CONTROL_BIT_SCAN_SIZE] == 1'b0) ?
                       {1'b0, chan_sel_ff[1:0]} : chan_sel_ff[2:0];
    assign csr_view = {end_flag_ff, irq_en_ff, start_ff, 1'b0, chan_sel_ff};
    assign start_wr = csr_wr && bus_wdata[`CONV_CONTROL_BIT_START];

    // control/status, control register and sequencer
    always_comb begin
        nxt_end_flag = end_flag_ff;
        nxt_irq_en = irq_en_ff;
        nxt_start = start_ff;
        nxt_chan_sel = chan_sel_ff;
        nxt_conv_control = conv_control_ff;
        nxt_flag_seen = flag_seen_ff;
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        conv_go = 1'b0;
        conv_abort = 1'b0;
        pass_end = 1'b0;
        result_we = 8'h00;
        if (bus_rd && bus_addr == `CONV_CONTROL_IDX_CTRL_STATUS && end_flag_ff) begin
            nxt_flag_seen = 1'b1;
        end
        if (csr_wr) begin
            nxt_irq_en = bus_wdata[`CONV_CONTROL_BIT_IRQ_EN];
            nxt_start = bus_wdata[`CONV_CONTROL_BIT_START];
            nxt_chan_sel = bus_wdata[3:0];
            // only a zero written after the flag was seen set, or a dma result fetch below, clears it
            if (!bus_wdata[`CONV_CONTROL_BIT_END_FLAG] && flag_seen_ff) begin
                nxt_end_flag = 1'b0;
                nxt_flag_seen = 1'b0;
            end
        end
        if (bus_wr && bus_addr == `CONV_CONTROL_IDX_CONV_CONTROL) begin
            nxt_conv_control = bus_wdata[7:0];
        end
        // dma fetch of a result acknowledges the end event while the interrupt is raised
        if (bus_rd && bus_dma && is_result(bus_addr) && irq_ff) begin
            nxt_end_flag = 1'b0;
            nxt_flag_seen = 1'b0;
        end
        if (trig_edge && !start_ff) begin
            nxt_start = 1'b1;
        end
        case (state_ff)
            CONV_CONTROL_IDLE: begin
                // prohibited single mode code never starts a conversion
                if ((start_ff || trig_edge) && !(chan_sel_ff[3] && !scan_en)) begin
                    nxt_cur = scan_en ? 3'h0 : chan_sel_ff[2:0];
                    conv_go = 1'b1;
                    nxt_state = CONV_CONTROL_CONV;
                end
            end
            CONV_CONTROL_CONV: begin
                if (csr_wr && !bus_wdata[`CONV_CONTROL_BIT_START]) begin
                    conv_abort = 1'b1;
                    nxt_state = CONV_CONTROL_IDLE;
                end else if (conv_done) begin
                    result_we[cur_ff] = 1'b1;
                    nxt_state = CONV_CONTROL_NEXT;
                    if (!scan_en || cur_ff == last_chan) begin
                        pass_end = 1'b1;
                    end
                end
            end
            CONV_CONTROL_NEXT: begin
                if (!scan_en) begin
                    nxt_start = start_wr;
                    nxt_state = CONV_CONTROL_IDLE;
                end else if (csr_wr && !bus_wdata[`CONV_CONTROL_BIT_START]) begin
                    nxt_state = CONV_CONTROL_IDLE;
                end else begin
                    nxt_cur = (cur_ff == last_chan) ? 3'h0 : conv_control_chan_t'(cur_ff + 3'h1);
                    conv_go = 1'b1;
                    nxt_state = CONV_CONTROL_CONV;
                end
            end
            default: begin
                nxt_state = CONV_CONTROL_IDLE;
            end
        endcase
        // a pass ending in the cycle of a clear wins over the clear
        if (pass_end) begin
            nxt_end_flag = 1'b1;
            nxt_flag_seen = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            end_flag_ff <= 1'(`CONV_CONTROL_CSR_RESET >> `CONV_CONTROL_BIT_END_FLAG);
            irq_en_ff <= 1'b0;
            start_ff <= 1'b0;
            chan_sel_ff <= 4'h0;
            conv_control_ff <= `CONV_CONTROL_CR_RESET;
            flag_seen_ff <= 1'b0;
            state_ff <= CONV_CONTROL_IDLE;
            cur_ff <= 3'h0;
            trig_prev_ff <= 1'b0;
        end else begin
            end_flag_ff <= nxt_end_flag;
            irq_en_ff <= nxt_irq_en;
            start_ff <= nxt_start;
            chan_sel_ff <= nxt_chan_sel;
            conv_control_ff <= nxt_conv_control;
            flag_seen_ff <= nxt_flag_seen;
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            trig_prev_ff <= trig_sync;
        end
    end

    // result storage; a read never touches it, only a finished conversion does
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_res
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    result_ff[gi] <= 10'h000;
                end else if (result_we[gi]) begin
                    result_ff[gi] <= sample_data;
                end
            end
        end
    endgenerate

    // read data, interrupt and analog side outputs all registered
    always_comb begin
        nxt_rdata = 16'h0000;
        if (bus_rd) begin
            if (is_result(bus_addr)) begin
                // byte reads of results are not supported; the six low bits are still zero
                nxt_rdata = {result_ff[bus_addr[2:0]], 6'h00};
            end else if (bus_addr == `CONV_CONTROL_IDX_CTRL_STATUS) begin
                nxt_rdata = {8'h00, csr_view};
            end else if (bus_addr == `CONV_CONTROL_IDX_CONV_CONTROL) begin
                nxt_rdata = {8'h00, conv_control_ff};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
            irq_ff <= 1'b0;
            sample_hold <= 1'b0;
            sample_chan <= 3'h0;
        end else begin
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_end_flag && nxt_irq_en;
            sample_hold <= (nxt_state == CONV_CONTROL_CONV);
            sample_chan <= nxt_cur;
        end
    end

    assign bus_rdata = rdata_ff;
    assign conv_end_irq = irq_ff;
endmodule

// ===== verification/adc_result_and_control_regs_test.sv
// self-checking bench for conv_control_top with the analog model
// assumes the bench is the only bus master
`timescale 1ns/1ps
module adc_result_and_control_regs_test;
    logic clk_sys = 0;
    logic rst = 1;
    logic bus_rd = 0;
    logic bus_wr = 0;
    logic bus_dma = 0;
    logic ext_trigger_u0 = 0;
    logic [3:0] bus_addr = 4'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:0] bus_rdata, rv;
    logic [9:0] sample_data;
    logic [2:0] sample_chan;
    logic sample_hold, conv_end_irq;
    int err_total = 0;
    int checked = 0;
    conv_control_top DUT (.clk_sys, .rst, .bus_addr, .bus_rd, .bus_wr, .bus_word(1'b1), .bus_wdata,
        .bus_dma, .bus_rdata, .ext_trigger_u0, .sample_data, .sample_chan, .sample_hold,
        .conv_end_irq);
    conv_control_analog_model u_core (.clk_sys, .sample_chan, .sample_hold, .sample_data);
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] exp_res(input int c);
        return {3'(c), 7'h4B, 6'h00};
    endfunction
    task automatic test_done();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1;
        @(negedge clk_sys);
        bus_wr = 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(negedge clk_sys);
        bus_addr = a;
        bus_rd = 1;
        @(negedge clk_sys);
        bus_rd = 0;
        rv = bus_rdata;
    endtask
    // bounded wait for one conversion to come and go
    task automatic wait_conv();
        int n = 0;
        logic seen = 0;
        while (!(seen && sample_hold === 1'b0) && n < 1000) begin
            seen |= sample_hold === 1'b1;
            @(negedge clk_sys);
            n++;
        end
        if (n == 1000) begin
            err_total++;
            test_done();
        end
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic t_chan_map();
        for (int c = 0; c < 8; c++) begin
            wr(4'h8, 16'h0020 | 16'(c));
            wait_conv();
            rd(4'h8);
            chk("csr end", 16'h0080 | 16'(c), rv);
            wr(4'h8, 16'h0080 | 16'(c));
            rd(4'h8);
            chk("csr keep", 16'h0080 | 16'(c), rv);
            wr(4'h8, 16'(c));
            rd(4'h8);
            chk("csr clr", 16'(c), rv);
            rd(4'(c));
            chk("result", exp_res(c), rv);
        end
    endtask
    task automatic t_retain();
        wr(4'h0, 16'hFFFF);
        rd(4'h0);
        chk("result ro", exp_res(0), rv);
        rd(4'hF);
        chk("unmapped", 16'h0000, rv);
        wr(4'h8, 16'h0028);
        repeat (5) @(negedge clk_sys);
        chk("bad code", 16'h0000, 16'(sample_hold));
        wr(4'h8, 16'h0000);
    endtask
    task automatic t_irq();
        wr(4'h8, 16'h0062);
        wait_conv();
        chk("irq on", 16'h0001, 16'(conv_end_irq));
        rd(4'h8);
        chk("csr irq", 16'h00C2, rv);
        wr(4'h8, 16'h0082);
        repeat (3) @(negedge clk_sys);
        chk("irq masked", 16'h0000, 16'(conv_end_irq));
        wr(4'h8, 16'h00C2);
        repeat (3) @(negedge clk_sys);
        chk("irq back", 16'h0001, 16'(conv_end_irq));
        bus_dma = 1;
        rd(4'h2);
        bus_dma = 0;
        repeat (3) @(negedge clk_sys);
        chk("dma clr", 16'h0000, 16'(conv_end_irq));
        rd(4'h8);
        chk("csr dma", 16'h0042, rv);
    endtask
    // scan over channels 0 and 1 keeps the start bit set until software clears it
    task automatic t_scan();
        int n = 0;
        wr(4'h9, 16'h0001);
        wr(4'h8, 16'h0061);
        while (conv_end_irq !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 3000) begin
            err_total++;
            test_done();
        end
        rd(4'h8);
        chk("scan csr", 16'h00E1, rv);
        wr(4'h8, 16'h0001);
        repeat (3) @(negedge clk_sys);
        chk("scan stop", 16'h0000, 16'(sample_hold));
        rd(4'h8);
        chk("scan clr", 16'h0001, rv);
        rd(4'h1);
        chk("scan result", exp_res(1), rv);
    endtask
    task automatic t_trigger();
        wr(4'h9, 16'h0004);
        wr(4'h8, 16'h0003);
        ext_trigger_u0 = 1;
        repeat (4) @(negedge clk_sys);
        ext_trigger_u0 = 0;
        wait_conv();
        rd(4'h8);
        chk("trig csr", 16'h0083, rv);
        rd(4'h3);
        chk("trig result", exp_res(3), rv);
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 0;
        rd(4'h8);
        chk("csr reset", 16'h0000, rv);
        t_chan_map();
        t_retain();
        t_irq();
        t_scan();
        t_trigger();
        test_done();
    end
endmodule

// ===== verification/conv_control_analog_model.sv
// analog core stand-in: a fixed level per channel while sampling
// assumes the hold and channel outputs of conv_control_top
`timescale 1ns/1ps
module conv_control_analog_model (
    input wire logic clk_sys,
    input wire logic [2:0] sample_chan,
    input wire logic sample_hold,
    output logic [9:0] sample_data
);
    logic hold_d;
    always_ff @(posedge clk_sys) begin
        hold_d <= sample_hold;
    end
    // inverted outside a conversion so a badly timed sample shows up
    assign sample_data = (sample_hold || hold_d) ? {sample_chan, 7'h4B} : ~{sample_chan, 7'h4B};
endmodule

// ===== verification/conv_control_assertions.sv
// port checker for conv_control_top, bound below
// assumes one clock, sync reset and the 850-cycle conversion
`timescale 1ns/1ps
module conv_control_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic [2:0] sample_chan,
    input wire logic sample_hold,
    input wire logic conv_end_irq
);
    logic [11:0] hold_cnt_ff;
    logic [11:0] nxt_hold_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_comb begin
        nxt_hold_cnt = sample_hold ? hold_cnt_ff + 12'h001 : 12'h000;
    end
    always_ff @(posedge clk_sys) begin
        hold_cnt_ff <= rst ? 12'h000 : nxt_hold_cnt;
    end
    a_reset_quiet: assert property ($fell(rst) |-> bus_rdata == 16'h0000 && !sample_hold && !conv_end_irq)
        else $error("outputs not quiet after reset");
    a_rdata_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
        else $error("read data without a read");
    a_result_low_zero: assert property ($past(bus_rd) && $past(bus_addr) < 4'h8 |-> bus_rdata[5:0] == 6'h00)
        else $error("result low bits not zero");
    a_csr_rsvd_zero: assert property ($past(bus_rd) && $past(bus_addr) == 4'h8 |-> bus_rdata[15:8] == 8'h00 && !bus_rdata[4])
        else $error("control reserved bits not zero");
    a_chan_steady: assert property ($rose(sample_hold) |=> $stable(sample_chan) [*8])
        else $error("channel moved during conversion");
    a_start_hold: assert property (bus_wr && bus_addr == 4'h8 && bus_wdata[5] && !bus_wdata[3] && !sample_hold |-> ##[1:3] sample_hold)
        else $error("start bit did not start");
    a_irq_needs_en: assert property (bus_wr && bus_addr == 4'h8 && !bus_wdata[6] |-> ##3 !conv_end_irq)
        else $error("interrupt with enable clear");
    // a stop by software may cut a conversion short, so only the upper bound is fixed
    a_conv_bound: assert property ($fell(sample_hold) |-> hold_cnt_ff <= 12'h353)
        else $error("conversion too long");
endmodule
bind conv_control_top conv_control_assertions u_chk (.clk_sys, .rst, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
    .bus_rdata, .sample_chan, .sample_hold, .conv_end_irq);
